// File: hdl/clock_divider.sv
`timescale 1ns/1ps

module clock_divider #(
    parameter int width = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [width-1:0] divide_by,
    // output
    output logic tick
);

    logic [width-1:0] count_q;
    logic [width-1:0] count_d;
    wire last_cycle;

    // ------------------------------------------------------------
    // divider: one tick every divide_by cycles, zero acts as one
    // ------------------------------------------------------------
    assign last_cycle = (count_q + width'(1) >= divide_by);
    assign count_d = !run ? '0 : (last_cycle ? '0 : count_q + width'(1));
    assign tick = run & last_cycle;

    // count state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule

// File: hdl/motor_pwm_compare_preload.sv
`timescale 1ns/1ps

module motor_pwm_compare_preload (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // pwm counter state from the counter logic
    input wire logic [motor_pwm_pkg::phase_w-1:0] pwm_count,
    input wire logic pwm_counting_up,
    // prescaler ticks
    output logic pwm_count_tick,
    output logic tacho_count_tick,
    // mode bits for the rest of the unit
    output logic counter_align_select,
    output logic direction_select,
    // update and active compares
    output logic update_event,
    output motor_pwm_pkg::compare_set_type active_compare,
    // pending flags
    output logic phase_v_match_flag,
    output logic phase_w_match_flag,
    output logic auto_transfer_flag
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    motor_pwm_pkg::reg_req_type req;
    logic [15:0] tacho_prescaler_q;
    logic [15:0] pwm_prescaler_q;
    logic [15:0] repetition_count_q;
    logic [15:0] phase_w_preload_q;
    logic [15:0] phase_v_preload_q;
    logic [15:0] phase_u_preload_q;
    logic [15:0] compare_zero_preload_q;
    logic [15:0] control_q;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic v_flag_q;
    logic w_flag_q;
    logic adt_flag_q;
    logic v_flag_d;
    logic w_flag_d;
    logic adt_flag_d;
    logic [motor_pwm_pkg::repeat_w-1:0] repeat_left_q;
    logic [motor_pwm_pkg::repeat_w-1:0] repeat_left_d;
    logic [motor_pwm_pkg::phase_w-1:0] prev_count_q;
    logic count_seen_q;
    motor_pwm_pkg::compare_set_type active_q;
    motor_pwm_pkg::compare_set_type active_d;

    // write strobe for one register offset
    function automatic logic wr_hit(input motor_pwm_pkg::reg_req_type r,
                                    input logic [7:0] off);
        wr_hit = r.wr && (r.addr == off);
    endfunction

    // keep only the implemented bits of a written value
    function automatic logic [15:0] keep(input logic [15:0] v,
                                         input int bits);
        keep = v & ((16'h0001 << bits) - 16'h0001);
    endfunction

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ------------------------------------------------------------
    // control bits
    // ------------------------------------------------------------
    // decoded control fields
    wire v_enable;
    wire w_enable;
    wire adt_enable;
    wire pwm_run;
    wire tacho_run;

    assign v_enable = control_q[motor_pwm_pkg::ctl_v_en_bit];
    assign w_enable = control_q[motor_pwm_pkg::ctl_w_en_bit];
    assign adt_enable = control_q[motor_pwm_pkg::ctl_adt_en_bit];
    assign pwm_run = control_q[motor_pwm_pkg::ctl_pwm_run_bit];
    assign tacho_run = control_q[motor_pwm_pkg::ctl_tacho_run_bit];
    assign counter_align_select = control_q[motor_pwm_pkg::ctl_align_bit];
    assign direction_select = control_q[motor_pwm_pkg::ctl_dir_bit];

    // ------------------------------------------------------------
    // prescalers
    // ------------------------------------------------------------
    clock_divider #(
        .width(motor_pwm_pkg::pwm_div_w)
    ) pwm_divider (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(pwm_run),
        .divide_by(pwm_prescaler_q[motor_pwm_pkg::pwm_div_w-1:0]),
        .tick(pwm_count_tick)
    );

    clock_divider #(
        .width(motor_pwm_pkg::tacho_div_w)
    ) tacho_divider (
        .clk_sys(clk_sys),
        .rst(rst),
        .run(tacho_run),
        .divide_by(tacho_prescaler_q[motor_pwm_pkg::tacho_div_w-1:0]),
        .tick(tacho_count_tick)
    );

    // ------------------------------------------------------------
    // counter arrival detection
    // ------------------------------------------------------------
    wire count_moved;
    wire at_zero;
    wire dir_ok;
    wire v_hit;
    wire w_hit;

    // an arrival is a new counter value, so a parked counter fires once
    assign count_moved = !count_seen_q || (pwm_count != prev_count_q);
    assign at_zero = count_moved && (pwm_count == '0);
    // center-aligned flags only in the chosen direction
    assign dir_ok = !counter_align_select
                    || (pwm_counting_up == direction_select);
    assign v_hit = count_moved && v_enable && dir_ok
                   && (pwm_count == active_q.v);
    assign w_hit = count_moved && w_enable && dir_ok
                   && (pwm_count == active_q.w);

    // ------------------------------------------------------------
    // repetition and update event
    // ------------------------------------------------------------
    wire [motor_pwm_pkg::repeat_w-1:0] repeat_value;

    assign repeat_value = repetition_count_q[motor_pwm_pkg::repeat_w-1:0];
    // update on the zero arrival whose remaining count is exhausted
    assign update_event = at_zero && (repeat_left_q == '0);
    // zero arrivals still to skip before the next update
    assign repeat_left_d = !at_zero ? repeat_left_q
                         : (repeat_left_q == '0) ? repeat_value
                         : repeat_left_q - 8'h01;

    // preloads move to the active set only on the update event
    assign active_d = update_event ? motor_pwm_pkg::compare_set_type'{
        u: phase_u_preload_q[motor_pwm_pkg::phase_w-1:0],
        v: phase_v_preload_q[motor_pwm_pkg::phase_w-1:0],
        w: phase_w_preload_q[motor_pwm_pkg::phase_w-1:0],
        zero: compare_zero_preload_q[motor_pwm_pkg::zero_w-1:0]
    } : active_q;

    // ------------------------------------------------------------
    // pending flags: a set in the clearing cycle wins
    // ------------------------------------------------------------
    wire pend_wr;
    wire v_clr;
    wire w_clr;
    wire adt_clr;

    // writing zero to a flag bit clears it, writing one leaves it
    assign pend_wr = wr_hit(req, motor_pwm_pkg::pending_off);
    assign v_clr = pend_wr && !reg_wdata[motor_pwm_pkg::pend_v_bit];
    assign w_clr = pend_wr && !reg_wdata[motor_pwm_pkg::pend_w_bit];
    assign adt_clr = pend_wr && !reg_wdata[motor_pwm_pkg::pend_adt_bit];
    assign v_flag_d = v_hit || (v_flag_q && !v_clr);
    assign w_flag_d = w_hit || (w_flag_q && !w_clr);
    assign adt_flag_d = (update_event && adt_enable)
                        || (adt_flag_q && !adt_clr);

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [15:0] pending_word;

    assign pending_word = {11'h000, adt_flag_q, 2'h0, v_flag_q, w_flag_q};

    always_comb begin
        case (reg_addr)
            motor_pwm_pkg::pending_off: rdata_d = pending_word;
            motor_pwm_pkg::tacho_prescaler_off: rdata_d = tacho_prescaler_q;
            motor_pwm_pkg::pwm_prescaler_off: rdata_d = pwm_prescaler_q;
            motor_pwm_pkg::repetition_count_off: rdata_d = repetition_count_q;
            motor_pwm_pkg::phase_w_preload_off: rdata_d = phase_w_preload_q;
            motor_pwm_pkg::phase_v_preload_off: rdata_d = phase_v_preload_q;
            motor_pwm_pkg::phase_u_preload_off: rdata_d = phase_u_preload_q;
            motor_pwm_pkg::compare_zero_preload_off: begin
                rdata_d = compare_zero_preload_q;
            end
            motor_pwm_pkg::control_off: rdata_d = control_q;
            default: rdata_d = 16'h0000; // unmapped reads zero
        endcase
    end

    // ------------------------------------------------------------
    // software registers (reserved bits stored as zero)
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tacho_prescaler_q <= motor_pwm_pkg::prescaler_rst;
            pwm_prescaler_q <= motor_pwm_pkg::prescaler_rst;
            repetition_count_q <= motor_pwm_pkg::preload_rst;
            control_q <= 16'h0000;
        end else begin
            if (wr_hit(req, motor_pwm_pkg::tacho_prescaler_off)) begin
                tacho_prescaler_q <= keep(reg_wdata,
                                          motor_pwm_pkg::tacho_div_w);
            end
            if (wr_hit(req, motor_pwm_pkg::pwm_prescaler_off)) begin
                pwm_prescaler_q <= keep(reg_wdata, motor_pwm_pkg::pwm_div_w);
            end
            if (wr_hit(req, motor_pwm_pkg::repetition_count_off)) begin
                repetition_count_q <= keep(reg_wdata,
                                           motor_pwm_pkg::repeat_w);
            end
            if (wr_hit(req, motor_pwm_pkg::control_off)) begin
                control_q <= reg_wdata & motor_pwm_pkg::control_mask;
            end
        end
    end

    // preload registers, which never touch the active set directly
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            phase_w_preload_q <= motor_pwm_pkg::preload_rst;
            phase_v_preload_q <= motor_pwm_pkg::preload_rst;
            phase_u_preload_q <= motor_pwm_pkg::preload_rst;
            compare_zero_preload_q <= motor_pwm_pkg::preload_rst;
        end else begin
            if (wr_hit(req, motor_pwm_pkg::phase_w_preload_off)) begin
                phase_w_preload_q <= keep(reg_wdata, motor_pwm_pkg::phase_w);
            end
            if (wr_hit(req, motor_pwm_pkg::phase_v_preload_off)) begin
                phase_v_preload_q <= keep(reg_wdata, motor_pwm_pkg::phase_w);
            end
            if (wr_hit(req, motor_pwm_pkg::phase_u_preload_off)) begin
                phase_u_preload_q <= keep(reg_wdata, motor_pwm_pkg::phase_w);
            end
            if (wr_hit(req, motor_pwm_pkg::compare_zero_preload_off)) begin
                compare_zero_preload_q <= keep(reg_wdata,
                                               motor_pwm_pkg::zero_w);
            end
        end
    end

    // ------------------------------------------------------------
    // block state
    // ------------------------------------------------------------
    // sticky pending flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            v_flag_q <= 1'b0;
            w_flag_q <= 1'b0;
            adt_flag_q <= 1'b0;
        end else begin
            v_flag_q <= v_flag_d;
            w_flag_q <= w_flag_d;
            adt_flag_q <= adt_flag_d;
        end
    end

    // repetition count, arrival history, active compares, read data
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            repeat_left_q <= '0;
            prev_count_q <= '0;
            count_seen_q <= 1'b0;
            active_q <= '0;
            rdata_q <= 16'h0000;
        end else begin
            repeat_left_q <= repeat_left_d;
            prev_count_q <= pwm_count;
            count_seen_q <= 1'b1;
            active_q <= active_d;
            rdata_q <= reg_rd ? rdata_d : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign active_compare = active_q;
    assign phase_v_match_flag = v_flag_q;
    assign phase_w_match_flag = w_flag_q;
    assign auto_transfer_flag = adt_flag_q;

endmodule

// File: hdl/motor_pwm_pkg.sv
package motor_pwm_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] pending_off = 8'h08;
    localparam logic [7:0] tacho_prescaler_off = 8'h0c;
    localparam logic [7:0] pwm_prescaler_off = 8'h10;
    localparam logic [7:0] repetition_count_off = 8'h14;
    localparam logic [7:0] phase_w_preload_off = 8'h18;
    localparam logic [7:0] phase_v_preload_off = 8'h1c;
    localparam logic [7:0] phase_u_preload_off = 8'h20;
    localparam logic [7:0] compare_zero_preload_off = 8'h24;
    localparam logic [7:0] control_off = 8'h40;

    // ------------------------------------------------------------
    // field widths and reset values
    // ------------------------------------------------------------
    localparam int tacho_div_w = 12;
    localparam int pwm_div_w = 8;
    localparam int repeat_w = 8;
    localparam int phase_w = 11;
    localparam int zero_w = 10;
    localparam logic [15:0] prescaler_rst = 16'h0001;
    localparam logic [15:0] preload_rst = 16'h0000;

    // ------------------------------------------------------------
    // bit positions
    // ------------------------------------------------------------
    localparam int pend_w_bit = 0;
    localparam int pend_v_bit = 1;
    localparam int pend_adt_bit = 4;
    localparam int ctl_v_en_bit = 0;
    localparam int ctl_w_en_bit = 1;
    localparam int ctl_align_bit = 2;
    localparam int ctl_adt_en_bit = 3;
    localparam int ctl_dir_bit = 4;
    localparam int ctl_pwm_run_bit = 5;
    localparam int ctl_tacho_run_bit = 6;
    localparam logic [15:0] control_mask = 16'h007f;
    localparam logic [15:0] pending_mask = 16'h0013;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_type;

    typedef struct packed {
        logic [phase_w-1:0] u;
        logic [phase_w-1:0] v;
        logic [phase_w-1:0] w;
        logic [zero_w-1:0] zero;
    } compare_set_type;

endpackage

// File: tb/motor_pwm_compare_preload_chk.sv
`timescale 1ns/1ps

module motor_pwm_compare_preload_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // counter state
    input wire logic [motor_pwm_pkg::phase_w-1:0] pwm_count,
    input wire logic pwm_counting_up,
    // block outputs
    input wire logic pwm_count_tick,
    input wire logic tacho_count_tick,
    input wire logic counter_align_select,
    input wire logic direction_select,
    input wire logic update_event,
    input wire motor_pwm_pkg::compare_set_type active_compare,
    input wire logic phase_v_match_flag,
    input wire logic phase_w_match_flag,
    input wire logic auto_transfer_flag
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // --------------------------------------------------------
    // software clear writes to the pending register
    // --------------------------------------------------------
    wire pend_wr = reg_wr && reg_addr == motor_pwm_pkg::pending_off;
    wire clr_v = pend_wr && !reg_wdata[motor_pwm_pkg::pend_v_bit];
    wire clr_w = pend_wr && !reg_wdata[motor_pwm_pkg::pend_w_bit];

    sequence no_read;
        !reg_rd;
    endsequence
    sequence transfer_step;
        update_event ##1 $rose(auto_transfer_flag);
    endsequence

    chk_v_flag_sticky: assert property (
        phase_v_match_flag && !clr_v |=> phase_v_match_flag)
        else $error("phase v flag dropped without clear");
    chk_w_flag_sticky: assert property (
        phase_w_match_flag && !clr_w |=> phase_w_match_flag)
        else $error("phase w flag dropped without clear");
    chk_v_set_match: assert property (
        $rose(phase_v_match_flag)
        |-> $past(pwm_count) == $past(active_compare.v))
        else $error("phase v flag set off compare value");
    chk_w_set_match: assert property (
        $rose(phase_w_match_flag)
        |-> $past(pwm_count) == $past(active_compare.w))
        else $error("phase w flag set off compare value");
    chk_center_dir: assert property (
        $rose(phase_v_match_flag) && $past(counter_align_select)
        |-> $past(pwm_counting_up) == $past(direction_select))
        else $error("center mode flag set in wrong direction");
    chk_update_at_zero: assert property (
        update_event |-> pwm_count == 11'h000)
        else $error("update event away from counter zero");
    chk_compare_hold: assert property (
        !update_event |=> $stable(active_compare))
        else $error("active compare changed without update");
    chk_transfer_cause: assert property (
        $rose(auto_transfer_flag) |-> $past(update_event))
        else $error("transfer flag set without update");
    chk_rdata_idle: assert property (
        no_read |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    cov_transfer: cover property (transfer_step);
endmodule

bind motor_pwm_compare_preload motor_pwm_compare_preload_chk chk_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pwm_count(pwm_count),
    .pwm_counting_up(pwm_counting_up), .pwm_count_tick(pwm_count_tick),
    .tacho_count_tick(tacho_count_tick),
    .counter_align_select(counter_align_select),
    .direction_select(direction_select), .update_event(update_event),
    .active_compare(active_compare),
    .phase_v_match_flag(phase_v_match_flag),
    .phase_w_match_flag(phase_w_match_flag),
    .auto_transfer_flag(auto_transfer_flag)
);

// File: tb/motor_pwm_compare_preload_tb_top.sv
`timescale 1ns/1ps

module motor_pwm_compare_preload_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [10:0] pwm_count = 11'h000;
    logic pwm_counting_up = 1'b1;
    logic [15:0] reg_rdata;
    logic pwm_count_tick, tacho_count_tick, update_event;
    logic counter_align_select, direction_select;
    logic phase_v_match_flag, phase_w_match_flag, auto_transfer_flag;
    motor_pwm_pkg::compare_set_type active_compare;
    int fails = 0;
    int samples_checked = 0;
    int n_upd = 0;
    int n_pt = 0;
    int n_tt = 0;
    int m0, m1;
    logic [7:0] offs [9] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c,
                             8'h20, 8'h24, 8'h30};
    logic [15:0] rstv [9] = '{16'h0000, 16'h0001, 16'h0001, 16'h0000,
                              16'h0000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0000};
    logic [15:0] mask [9] = '{16'h0000, 16'h0fff, 16'h00ff, 16'h00ff,
                              16'h07ff, 16'h07ff, 16'h07ff, 16'h03ff,
                              16'h0000};
    // expected active set after the update at the counter's return to zero: u, v, w, zero
    localparam logic [42:0] loaded_cmp = {11'h123, 11'h050,
                                          11'h060, 10'h0a0};
    wire [15:0] flags_vw = {14'h0000, phase_v_match_flag, phase_w_match_flag};
    wire [15:0] modes = {14'h0000, counter_align_select, direction_select};

    // clock and event counters
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        n_upd += (update_event === 1'b1);
        n_pt += (pwm_count_tick === 1'b1);
        n_tt += (tacho_count_tick === 1'b1);
    end

    motor_pwm_compare_preload dut (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pwm_count(pwm_count),
        .pwm_counting_up(pwm_counting_up), .pwm_count_tick(pwm_count_tick),
        .tacho_count_tick(tacho_count_tick),
        .counter_align_select(counter_align_select),
        .direction_select(direction_select), .update_event(update_event),
        .active_compare(active_compare),
        .phase_v_match_flag(phase_v_match_flag),
        .phase_w_match_flag(phase_w_match_flag),
        .auto_transfer_flag(auto_transfer_flag)
    );

    // ----------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // new counter value, returns just after the edge ending that cycle
    task automatic cnt(input logic [10:0] v);
        @(posedge clk_sys);
        pwm_count <= v;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog
    initial begin
        #1000000;
        fails++;
        end_sim;
    end

    // ----------------------------------------------------
    // test sequence
    // ----------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) rd(offs[i], rstv[i]);
        for (int i = 0; i < 9; i++) begin
            wr(offs[i], mask[i]);
            rd(offs[i], mask[i]);
        end
        $display("test registers done");
        wr(8'h14, 16'h0000);
        wr(8'h20, 16'h0123);
        wr(8'h1c, 16'h0050);
        wr(8'h18, 16'h0060);
        wr(8'h24, 16'h00a0);
        wr(8'h40, 16'h000b);
        chk(16'(active_compare.v), 16'h0000);
        cnt(11'h005);
        m0 = n_upd;
        cnt(11'h000);
        chk(16'(n_upd - m0), 16'h0001);
        samples_checked++;
        if (active_compare !== loaded_cmp) begin
            fails++;
            $display("Error %0t: active compare %h", $time, active_compare);
        end
        chk({15'h0000, auto_transfer_flag}, 16'h0001);
        $display("test update done");
        // zero arrival met the old zero compares: drop v and w, keep transfer
        wr(8'h08, 16'h0010);
        cnt(11'h050);
        chk(flags_vw, 16'h0002);
        cnt(11'h060);
        chk(flags_vw, 16'h0003);
        cnt(11'h007);
        rd(8'h08, 16'h0013);
        wr(8'h08, 16'h0011);
        rd(8'h08, 16'h0011);
        wr(8'h08, 16'h0000);
        rd(8'h08, 16'h0000);
        $display("test flags done");
        wr(8'h40, 16'h0017);
        chk(modes, 16'h0003);
        @(posedge clk_sys);
        pwm_counting_up <= 1'b0;
        cnt(11'h050);
        chk({15'h0000, phase_v_match_flag}, 16'h0000);
        cnt(11'h001);
        @(posedge clk_sys);
        pwm_counting_up <= 1'b1;
        cnt(11'h050);
        chk({15'h0000, phase_v_match_flag}, 16'h0001);
        $display("test center done");
        wr(8'h14, 16'h0002);
        m0 = n_upd;
        repeat (4) begin
            cnt(11'h000);
            cnt(11'h001);
        end
        chk(16'(n_upd - m0), 16'h0002);
        $display("test repetition done");
        wr(8'h10, 16'h0003);
        wr(8'h0c, 16'h0005);
        wr(8'h40, 16'h0060);
        repeat (10) @(posedge clk_sys);
        #1;
        m0 = n_pt;
        m1 = n_tt;
        repeat (30) @(posedge clk_sys);
        #1;
        chk(16'(n_pt - m0), 16'h000a);
        chk(16'(n_tt - m1), 16'h0006);
        $display("test prescalers done");
        end_sim;
    end
endmodule
